// [cpu_model.sv]
// Purpose: CPU core model driving the priority registers over AXI4-Lite
// Assumes: One write and one read in flight at most
// Notes: stall delays bready/rready to model a slow core
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
	input wire logic clk,
	output logic [3:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [3:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	int stall = 0;
	// Idle bus at time zero
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			ad = ad | awready;
			wd = wd | wready;
			if (awready) awvalid <= 1'b0;
			if (wready) wdata <= ~d;
			if (wready) wvalid <= 1'b0;
		end while (!(ad && wd));
		repeat (stall) @(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	// Read: address held until taken, data taken with rready high
	task automatic rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		repeat (stall) @(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
endmodule : cpu_model
`default_nettype wire

// [irq_priority_fields_timer_ext_tb.sv]
// Purpose: Self-checking bench for the priority register block
// Assumes: Fixed seed, both device variants exercised
// Notes: Expected values come from a shadow copy of the fields
`timescale 1ns/1ps
`default_nettype none
module irq_priority_fields_timer_ext_tb;
	import prio_pkg::*;
	logic clk, rst_b, large_variant, lg;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [2:0] t4l, e2l, t5l, t4, e2, t5;
	logic t4a, e2a, t5a;
	int failures = 0;
	int n_tests = 0;
	prio_regs prio_regs_i (.clk(clk), .rst_b(rst_b),
		.large_variant(large_variant), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .timer4_level_field(t4l),
		.ext2_level_field(e2l), .timer5_level_field(t5l),
		.timer4_active(t4a), .ext2_active(e2a), .timer5_active(t5a));
	cpu_model cpu_i (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	// Expected read word for a mapped offset
	function automatic logic [31:0] exp_rd(input logic [3:0] a);
		if (a == 4'h0) return {17'h0, lg ? t4 : 3'h0, 12'h000};
		if (a == 4'h4) return {25'h0, e2, 1'b0, lg ? t5 : 3'h0};
		return {31'h0, lg};
	endfunction : exp_rd
	task automatic chk_ports();
		chk("ext2 level", e2l, e2);
		chk("ext2 active", e2a, e2 != 3'h0);
		chk("t4 active", t4a, lg && t4 != 3'h0);
		chk("t5 active", t5a, lg && t5 != 3'h0);
		chk("t4 level", t4l, t4);
		chk("t5 level", t5l, t5);
	endtask : chk_ports
	task automatic do_wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s);
		logic [1:0] r;
		cpu_i.stall = $urandom_range(0, 2);
		cpu_i.wr(a, d, s, r);
		if (a == 4'h0 && s[1] && lg) t4 = d[14:12];
		if (a == 4'h4 && s[0]) e2 = d[6:4];
		if (a == 4'h4 && s[0] && lg) t5 = d[2:0];
		chk("bresp", r, a > 4'h8 ? RESP_SLVERR : RESP_OKAY);
		chk_ports();
	endtask : do_wr
	task automatic do_rd(input logic [3:0] a);
		logic [31:0] d;
		logic [1:0] r;
		cpu_i.stall = $urandom_range(0, 2);
		cpu_i.rd(a, d, r);
		chk("rresp", r, a > 4'h8 ? RESP_SLVERR : RESP_OKAY);
		if (a <= 4'h8) chk("rdata", d, exp_rd(a));
	endtask : do_rd
	task automatic do_reset(input logic v);
		rst_b <= 1'b0;
		large_variant <= v;
		lg = v;
		{t4, e2, t5} = {3{LEVEL_RESET}};
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 16; i += 4) do_rd(4'(i));
		chk_ports();
		$display("test reset done, large %0d", v);
	endtask : do_reset
	// Random traffic over mapped and unmapped offsets
	task automatic run_random(input int n);
		logic [3:0] a;
		for (int k = 0; k < n; k++) begin
			a = 4'($urandom_range(0, 3) * 4);
			if (a == 4'h8) a = 4'hC;
			do_wr(a, $urandom, 4'($urandom));
			do_rd(4'($urandom_range(0, 3) * 4));
		end
		$display("test random done");
	endtask : run_random
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	// Watchdog
	initial begin
		#(20000 * 50);
		failures++;
		give_verdict();
	end
	initial begin
		rst_b = 1'b0;
		large_variant = 1'b1;
		lg = 1'b1;
		void'($urandom(19658));
		do_reset(1'b1);
		// Every code in every field, junk in unimplemented bits
		for (int c = 0; c < 8; c++) begin
			do_wr(4'h0, 32'hFFFF_8FFF | (c << 12), 4'hF);
			do_wr(4'h4, 32'hFFFF_FF88 | (c << 4) | (7 - c), 4'hF);
			do_rd(4'h0);
			do_rd(4'h4);
		end
		// Missing byte lanes and unmapped offset leave fields alone
		do_wr(4'h0, 32'h0000_7000, 4'hD);
		do_wr(4'h4, 32'h0000_0077, 4'hE);
		do_wr(4'hC, 32'h0000_0000, 4'hF);
		do_rd(4'hC);
		$display("test codes done");
		run_random(40);
		do_reset(1'b0);
		do_wr(4'h0, 32'h0000_7000, 4'hF);
		do_wr(4'h4, 32'h0000_0077, 4'hF);
		run_random(20);
		give_verdict();
	end
endmodule : irq_priority_fields_timer_ext_tb
`default_nettype wire

// [level_field.sv]
// Purpose: One three-bit priority field with reset value and write gate
// Assumes: Write strobe already qualified by address and byte lane
// Notes: Also flags whether the source is presented (code not zero)
`timescale 1ns/1ps
`default_nettype none
module level_field (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic present,
	input wire logic wr,
	input wire logic [prio_pkg::LEVEL_W-1:0] wdata,
	output logic [prio_pkg::LEVEL_W-1:0] level,
	output logic active
);
	import prio_pkg::*;

	// Field storage; absent variants never store
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			level <= LEVEL_RESET;
		end else if (wr && present) begin
			level <= wdata;
		end
	end

	// Source presented only when enabled and present
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			active <= 1'b0;
		end else begin
			active <= present && (next_level_nz());
		end
	end

	function automatic logic next_level_nz();
		return (wr && present) ? (wdata != LEVEL_DISABLED)
			: (level != LEVEL_DISABLED);
	endfunction : next_level_nz

	chk_field_reset_hold: assert property (@(posedge clk)
		disable iff (!rst_b) !present |-> level == LEVEL_RESET)
		else $error("absent field changed");
	chk_field_disabled: assert property (@(posedge clk)
		disable iff (!rst_b) level == LEVEL_DISABLED |=> !active || $past(wr))
		else $error("disabled source presented");

endmodule : level_field
`default_nettype wire

// [prio_pkg.sv]
// Purpose: Shared constants for the timer/external priority register block
// Assumes: 32-bit AXI4-Lite data, 16-bit registers in the low half
// Notes: Offsets are byte addresses of aligned words
package prio_pkg;

	localparam int ADDR_W = 4;
	localparam int LEVEL_W = 3;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] TIMER4_PRIORITY_CTRL_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] EXT2_TIMER5_PRIORITY_CTRL_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] VARIANT_STATUS_OFS = 4'h8;

	// Field positions (low bit of each 3-bit field)
	localparam int TIMER4_LEVEL_LSB = 12;
	localparam int EXT2_LEVEL_LSB = 4;
	localparam int TIMER5_LEVEL_LSB = 0;

	// Level codes
	localparam logic [LEVEL_W-1:0] LEVEL_RESET = 3'h4;
	localparam logic [LEVEL_W-1:0] LEVEL_DISABLED = 3'h0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : prio_pkg

// [prio_regs.sv]
// Purpose: Timer 4, timer 5 and external 2 priority registers on AXI4-Lite
// Assumes: Master keeps one read and one write in flight at most
// Notes: Levels 1..7 leave as ports; zero code means source disabled
//
// How it works
// - Each field is three bits, 111 is level 7, timer 4 sits in bits 14:12.
// - Code 001 is level 1 and higher codes give higher levels in order.
// - A field holding 000 disables its source, which is never presented.
// - Unimplemented bits of both registers read as zero.
// - External interrupt 2 level sits in bits 6:4 of the second register.
// - Timer 5 level sits in bits 2:0 of the second register.
// - Every implemented field resets to 100, level 4.
// - Timer 4 and timer 5 fields exist only in the large-memory variant.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module prio_regs (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic large_variant,
	input wire logic [prio_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [prio_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [prio_pkg::LEVEL_W-1:0] timer4_level_field,
	output logic [prio_pkg::LEVEL_W-1:0] ext2_level_field,
	output logic [prio_pkg::LEVEL_W-1:0] timer5_level_field,
	output logic timer4_active,
	output logic ext2_active,
	output logic timer5_active
);
	import prio_pkg::*;

	// ----------------------------------------
	// Variant strap
	// ----------------------------------------
	logic variant;
	logic strap_done;

	// Strap caught by the clock after reset release
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			variant <= 1'b0;
			strap_done <= 1'b0;
		end else if (!strap_done) begin
			variant <= large_variant;
			strap_done <= 1'b1;
		end
	end

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	logic [ADDR_W-1:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic do_write;

	assign do_write = aw_held && w_held && !s_axi_bvalid;

	// Address and data accepted in either order
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	// Write response; unmapped offsets answer SLVERR
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			if (aw_addr == TIMER4_PRIORITY_CTRL_OFS) begin
				s_axi_bresp <= RESP_OKAY;
			end else if (aw_addr == EXT2_TIMER5_PRIORITY_CTRL_OFS) begin
				s_axi_bresp <= RESP_OKAY;
			end else if (aw_addr == VARIANT_STATUS_OFS) begin
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Priority fields
	// ----------------------------------------
	logic wr_reg1;
	logic wr_reg2;

	// Only the byte lane holding a field writes it
	assign wr_reg1 = do_write && aw_addr == TIMER4_PRIORITY_CTRL_OFS
		&& w_strb[1];
	assign wr_reg2 = do_write && aw_addr == EXT2_TIMER5_PRIORITY_CTRL_OFS
		&& w_strb[0];

	level_field u_timer4 (
		.clk(clk),
		.rst_b(rst_b),
		.present(variant),
		.wr(wr_reg1),
		.wdata(w_data[TIMER4_LEVEL_LSB +: LEVEL_W]),
		.level(timer4_level_field),
		.active(timer4_active)
	);

	level_field u_ext2 (
		.clk(clk),
		.rst_b(rst_b),
		.present(1'b1),
		.wr(wr_reg2),
		.wdata(w_data[EXT2_LEVEL_LSB +: LEVEL_W]),
		.level(ext2_level_field),
		.active(ext2_active)
	);

	level_field u_timer5 (
		.clk(clk),
		.rst_b(rst_b),
		.present(variant),
		.wr(wr_reg2),
		.wdata(w_data[TIMER5_LEVEL_LSB +: LEVEL_W]),
		.level(timer5_level_field),
		.active(timer5_active)
	);

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;
	logic [ADDR_W-1:0] rd_addr;

	// Read mux; unimplemented bits stay zero
	always_comb begin
		next_rdata = '0;
		next_rresp = RESP_OKAY;
		if (s_axi_araddr == TIMER4_PRIORITY_CTRL_OFS) begin
			next_rdata[TIMER4_LEVEL_LSB +: LEVEL_W] =
				variant ? timer4_level_field : LEVEL_DISABLED;
		end else if (s_axi_araddr == EXT2_TIMER5_PRIORITY_CTRL_OFS) begin
			next_rdata[EXT2_LEVEL_LSB +: LEVEL_W] = ext2_level_field;
			next_rdata[TIMER5_LEVEL_LSB +: LEVEL_W] =
				variant ? timer5_level_field : LEVEL_DISABLED;
		end else if (s_axi_araddr == VARIANT_STATUS_OFS) begin
			next_rdata[0] = variant;
		end else begin
			next_rresp = RESP_SLVERR;
		end
	end

	// One-cycle address accept, data registered on acceptance
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
			rd_addr <= '0;
		end else begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready
				&& !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rresp;
				rd_addr <= s_axi_araddr; // Offset behind the read word
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Upper half is always zero; the low unused bits depend on the offset
	chk_reg1_zero_bits: assert property (@(posedge clk)
		disable iff (!rst_b) s_axi_rvalid |-> s_axi_rdata[31:15] == '0
		&& (rd_addr != TIMER4_PRIORITY_CTRL_OFS || s_axi_rdata[11:0] == '0))
		else $error("unimplemented bits read nonzero");
	chk_reg2_bit3: assert property (@(posedge clk)
		disable iff (!rst_b) s_axi_rvalid |-> !s_axi_rdata[3]
		&& (rd_addr != EXT2_TIMER5_PRIORITY_CTRL_OFS || s_axi_rdata[31:7] == '0))
		else $error("bit 3 read nonzero");
	chk_ext2_write: assert property (@(posedge clk)
		disable iff (!rst_b) wr_reg2 |=> ext2_level_field == $past(w_data[6:4]))
		else $error("ext2 field not written");
	chk_timer5_write: assert property (@(posedge clk)
		disable iff (!rst_b)
		wr_reg2 && variant |=> timer5_level_field == $past(w_data[2:0]))
		else $error("timer5 field not written");
	chk_timer4_write: assert property (@(posedge clk)
		disable iff (!rst_b)
		wr_reg1 && variant |=> timer4_level_field == $past(w_data[14:12]))
		else $error("timer4 field not written");
	chk_no_stray_write: assert property (@(posedge clk)
		disable iff (!rst_b) !wr_reg2 |=> $stable(ext2_level_field))
		else $error("ext2 field changed without write");
	chk_active_code: assert property (@(posedge clk)
		disable iff (!rst_b) ext2_active |-> ext2_level_field >= 3'h1)
		else $error("active with code zero");
	chk_read_answer: assert property (@(posedge clk)
		disable iff (!rst_b) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	chk_absent_reads_zero: assert property (@(posedge clk)
		disable iff (!rst_b)
		s_axi_rvalid && !variant && s_axi_rresp == RESP_OKAY
		|-> s_axi_rdata[14:12] == '0 && s_axi_rdata[2:0] == '0)
		else $error("absent field read nonzero");
	chk_reset_level: assert property (@(posedge clk)
		$rose(rst_b) |-> ext2_level_field == LEVEL_RESET)
		else $error("reset level wrong");

	cov_write: cover property (@(posedge clk) disable iff (!rst_b) do_write);
	cov_read: cover property (@(posedge clk) disable iff (!rst_b)
		s_axi_rvalid && s_axi_rready);
	cov_disable: cover property (@(posedge clk) disable iff (!rst_b)
		$fell(ext2_active));

endmodule : prio_regs
`default_nettype wire
